// ===== design/wide_mul_div_unit.v
// Operation
// - both mode bits clear: classic byte multiply and byte divide
// - 16x16 multiply operands {acc_ext_lo,A},{b_ext,B}; product into b_ext,B,A,acc_ext_lo
// - wide multiply sets overflow when upper product bytes are nonzero
// - 16x16 multiply finishes in 16 clock cycles
// - 16/16 divide: quotient A,acc_ext_lo; remainder B,b_ext; zero divisor sets overflow
// - 16/16 divide finishes in 16 clock cycles
// - 32/16 dividend from acc_ext_top,acc_ext_mid,acc_ext_lo,A; divisor {b_ext,B}
// - 32/16 quotient into A,acc_ext_lo,acc_ext_mid,acc_ext_top; remainder B,b_ext
// - 32/16 divide finishes in 32 clock cycles
// - long_div_sel only matters with wide_arith_sel set; selects 32/16 divide
// - wide_arith_sel chooses byte or wide operation for multiply and divide
// - all widths use the same multiply and divide opcodes; 8, 16 or 32 cycles
`timescale 1ns/1ps
`include "wide_mul_div_regs.vh"
module wide_mul_div_unit (
  input  wire       mclk,
  input  wire       sys_rst,
  input  wire       opStart,
  input  wire [7:0] opCode,
  input  wire [7:0] accIn,
  input  wire [7:0] bIn,
  input  wire       sfrWr,
  input  wire [7:0] sfrAddr,
  input  wire [7:0] sfrWdata,
  output wire [7:0] sfrRdata,
  output wire [7:0] accOut,
  output wire [7:0] bOut,
  output wire       abWrite,
  output wire       ovOut,
  output wire       carryOut,
  output wire       flagWrite,
  output wire       busy
);

////////////////////////////////////////////////////////////////////////////////
localparam ST_IDLE = 3'b001;
localparam ST_RUN  = 3'b010;
localparam ST_DONE = 3'b100;

reg [2:0]  state_ff;
reg [5:0]  cnt_ff;
reg        isMul_ff;
reg        modeWide_ff;
reg        modeLong_ff;
reg [7:0]  accExtLo_ff;
reg [7:0]  accExtMid_ff;
reg [7:0]  accExtTop_ff;
reg [7:0]  bExt_ff;
reg [7:0]  ctrl_ff;
reg [31:0] quo_ff;
reg [16:0] rem_ff;
reg [15:0] dvs_ff;
reg [31:0] prod_ff;
reg [31:0] mcand_ff;
reg [7:0]  sfrRdata_ff;
reg [7:0]  accOut_ff;
reg [7:0]  bOut_ff;
reg        abWrite_ff;
reg        ovOut_ff;
reg        carryOut_ff;
reg        flagWrite_ff;
reg        busy_ff;

////////////////////////////////////////////////////////////////////////////////
// opcode decode, shared by issue and operand load
function isMulOp;
  input [7:0] op;
  begin
    isMulOp = (op == `OPC_MUL);
  end
endfunction

function isArithOp;
  input [7:0] op;
  begin
    isArithOp = (op == `OPC_MUL) || (op == `OPC_DIV);
  end
endfunction

// run length per mode; long_div_sel matters only for a wide divide
function [5:0] runLength;
  input wideOp;
  input longOp;
  input mulOp;
  begin
    if (!wideOp)
      runLength = `CYC_BYTE;
    else if (mulOp || !longOp)
      runLength = `CYC_WIDE;
    else
      runLength = `CYC_LONG;
  end
endfunction

wire       wideSel = ctrl_ff[`BIT_WIDE_ARITH];
wire       longSel = ctrl_ff[`BIT_LONG_DIV];
wire       isIdle  = (state_ff == ST_IDLE);
wire       isRun   = (state_ff == ST_RUN);
wire       isDone  = (state_ff == ST_DONE);
wire       takeOp  = opStart && isIdle && isArithOp(opCode);
wire       sfrTake = sfrWr && isIdle;

// one restoring step; divisor width fixed at 16 so byte mode reuses it
function [48:0] divStep;
  input [16:0] r;
  input [31:0] q;
  input [15:0] d;
  reg   [16:0] t;
  begin
    t = {r[15:0], q[31]};
    if (t >= {1'b0, d})
      divStep = {t - {1'b0, d}, q[30:0], 1'b1};
    else
      divStep = {t, q[30:0], 1'b0};
  end
endfunction

wire [48:0] stepRes = divStep(rem_ff, quo_ff, dvs_ff);

////////////////////////////////////////////////////////////////////////////////
// sfr read mux, unmapped reads zero
always @(posedge mclk) begin
  if (sys_rst)
    sfrRdata_ff <= `RST_BYTE;
  else begin
    case (sfrAddr)
      `ADDR_ACC_EXT_MID: sfrRdata_ff <= accExtMid_ff;
      `ADDR_ACC_EXT_TOP: sfrRdata_ff <= accExtTop_ff;
      `ADDR_ACC_EXT_LO:  sfrRdata_ff <= accExtLo_ff;
      `ADDR_B_EXT:       sfrRdata_ff <= bExt_ff;
      `ADDR_MISC_CTRL2:  sfrRdata_ff <= ctrl_ff;
      default:           sfrRdata_ff <= `RST_BYTE;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
always @(posedge mclk) begin
  if (sys_rst)
    ctrl_ff <= `RST_BYTE;
  else if (sfrTake && sfrAddr == `ADDR_MISC_CTRL2)
    ctrl_ff <= sfrWdata & `MISC_CTRL2_MASK;
end

////////////////////////////////////////////////////////////////////////////////
// sfr writes are ignored mid-operation so operands stay stable
always @(posedge mclk) begin
  if (sys_rst) begin
    accExtLo_ff  <= `RST_BYTE;
    accExtMid_ff <= `RST_BYTE;
    accExtTop_ff <= `RST_BYTE;
    bExt_ff      <= `RST_BYTE;
  end else if (sfrTake) begin
    case (sfrAddr)
      `ADDR_ACC_EXT_MID: accExtMid_ff <= sfrWdata;
      `ADDR_ACC_EXT_TOP: accExtTop_ff <= sfrWdata;
      `ADDR_ACC_EXT_LO:  accExtLo_ff  <= sfrWdata;
      `ADDR_B_EXT:       bExt_ff      <= sfrWdata;
      default:           ;
    endcase
  end else if (isDone && modeWide_ff) begin
    if (isMul_ff) begin
      bExt_ff     <= prod_ff[31:24];
      accExtLo_ff <= prod_ff[7:0];
    end else if (modeLong_ff) begin
      accExtLo_ff  <= quo_ff[23:16];
      accExtMid_ff <= quo_ff[15:8];
      accExtTop_ff <= quo_ff[7:0];
      bExt_ff      <= rem_ff[7:0];
    end else begin
      accExtLo_ff <= quo_ff[7:0];
      bExt_ff     <= rem_ff[7:0];
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
always @(posedge mclk) begin
  if (sys_rst) begin
    state_ff    <= ST_IDLE;
    cnt_ff      <= `CNT_ZERO;
    isMul_ff    <= 1'b0;
    modeWide_ff <= 1'b0;
    modeLong_ff <= 1'b0;
    busy_ff     <= 1'b0;
  end else begin
    case (state_ff)
      ST_IDLE: begin
        if (takeOp) begin
          state_ff    <= ST_RUN;
          busy_ff     <= 1'b1;
          isMul_ff    <= isMulOp(opCode);
          modeWide_ff <= wideSel;
          modeLong_ff <= wideSel & longSel;
          cnt_ff      <= runLength(wideSel, longSel, isMulOp(opCode));
        end
      end
      ST_RUN: begin
        cnt_ff <= cnt_ff - `CNT_ONE;
        if (cnt_ff == `CNT_ONE)
          state_ff <= ST_DONE;
      end
      ST_DONE: begin
        state_ff <= ST_IDLE;
        busy_ff  <= 1'b0;
      end
      default: begin
        state_ff <= ST_IDLE;
        busy_ff  <= 1'b0;
      end
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
always @(posedge mclk) begin
  if (sys_rst) begin
    quo_ff   <= `ZERO_WORD;
    rem_ff   <= `ZERO_REM;
    dvs_ff   <= `ZERO_HALF;
    prod_ff  <= `ZERO_WORD;
    mcand_ff <= `ZERO_WORD;
  end else if (takeOp) begin
    prod_ff <= `ZERO_WORD;
    rem_ff  <= `ZERO_REM;
    if (!wideSel) begin
      mcand_ff <= {`ZERO_HALF, `RST_BYTE, accIn};
      dvs_ff   <= {`RST_BYTE, bIn};
      quo_ff   <= {accIn, `RST_BYTE, `ZERO_HALF};
    end else if (isMulOp(opCode)) begin
      mcand_ff <= {`ZERO_HALF, accExtLo_ff, accIn};
      dvs_ff   <= {bExt_ff, bIn};
    end else if (longSel) begin
      quo_ff <= {accExtTop_ff, accExtMid_ff, accExtLo_ff, accIn};
      dvs_ff <= {bExt_ff, bIn};
    end else begin
      quo_ff <= {accExtLo_ff, accIn, `ZERO_HALF};
      dvs_ff <= {bExt_ff, bIn};
    end
  end else if (isRun) begin
    // shift-add multiply, lsb of multiplier first, one bit per cycle
    if (isMul_ff) begin
      if (dvs_ff[0])
        prod_ff <= prod_ff + mcand_ff;
      mcand_ff <= {mcand_ff[30:0], 1'b0};
      dvs_ff   <= {1'b0, dvs_ff[15:1]};
    end else begin
      rem_ff <= stepRes[48:32];
      quo_ff <= stepRes[31:0];
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
always @(posedge mclk) begin
  if (sys_rst) begin
    accOut_ff    <= `RST_BYTE;
    bOut_ff      <= `RST_BYTE;
    ovOut_ff     <= 1'b0;
    carryOut_ff  <= 1'b0;
    abWrite_ff   <= 1'b0;
    flagWrite_ff <= 1'b0;
  end else begin
    // one-cycle strobes because the done state lasts one cycle
    abWrite_ff   <= isDone;
    flagWrite_ff <= isDone;
    if (isDone) begin
      carryOut_ff <= 1'b0;
      if (isMul_ff) begin
        if (!modeWide_ff) begin
          accOut_ff <= prod_ff[7:0];
          bOut_ff   <= prod_ff[15:8];
          ovOut_ff  <= (prod_ff[15:8] != `RST_BYTE);
        end else begin
          bOut_ff   <= prod_ff[23:16];
          accOut_ff <= prod_ff[15:8];
          ovOut_ff  <= (prod_ff[31:16] != `ZERO_HALF);
        end
      end else begin
        // zero divisor: quotient and remainder are whatever the loop leaves
        ovOut_ff <= (dvs_ff == `ZERO_HALF);
        if (!modeWide_ff) begin
          accOut_ff <= quo_ff[7:0];
          bOut_ff   <= rem_ff[7:0];
        end else if (modeLong_ff) begin
          accOut_ff <= quo_ff[31:24];
          bOut_ff   <= rem_ff[15:8];
        end else begin
          accOut_ff <= quo_ff[15:8];
          bOut_ff   <= rem_ff[15:8];
        end
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
assign sfrRdata  = sfrRdata_ff;
assign accOut    = accOut_ff;
assign bOut      = bOut_ff;
assign abWrite   = abWrite_ff;
assign ovOut     = ovOut_ff;
assign carryOut  = carryOut_ff;
assign flagWrite = flagWrite_ff;
assign busy      = busy_ff;

endmodule

// ===== include/wide_mul_div_regs.vh
`ifndef WIDE_MUL_DIV_REGS_VH
`define WIDE_MUL_DIV_REGS_VH
`define ADDR_ACC_EXT_MID   8'hce
`define ADDR_ACC_EXT_TOP   8'hcf
`define ADDR_ACC_EXT_LO    8'he6
`define ADDR_B_EXT         8'he7
`define ADDR_MISC_CTRL2    8'hf7
`define RST_BYTE           8'h00
`define BIT_WIDE_ARITH     0
`define BIT_LONG_DIV       3
`define MISC_CTRL2_MASK    8'hfd
`define OPC_MUL            8'ha4
`define OPC_DIV            8'h84
`define CYC_BYTE           6'd8
`define CYC_WIDE           6'd16
`define CYC_LONG           6'd32
`define CNT_ONE            6'd1
`define CNT_ZERO           6'd0
`define ZERO_HALF          16'h0000
`define ZERO_REM           17'h00000
`define ZERO_WORD          32'h00000000
`endif

// ===== verif/core_model.sv
`timescale 1ns/1ps
module core_model (
  input  wire        mclk,
  input  wire  [7:0] sfrRdata,
  input  wire  [7:0] accOut,
  input  wire  [7:0] bOut,
  input  wire        abWrite,
  input  wire        ovOut,
  input  wire        carryOut,
  output logic       opStart = 1'b0,
  output logic [7:0] opCode = 8'h00,
  output logic [7:0] accIn = 8'h00,
  output logic [7:0] bIn = 8'h00,
  output logic       sfrWr = 1'b0,
  output logic [7:0] sfrAddr = 8'h00,
  output logic [7:0] sfrWdata = 8'h00
);
  // released data lines show the inverse so stale values never look valid
  task wr(input [7:0] a, input [7:0] d);
    @(negedge mclk);
    sfrWr = 1'b1;
    sfrAddr = a;
    sfrWdata = d;
    @(negedge mclk);
    sfrWr = 1'b0;
    sfrWdata = ~d;
  endtask
  task rd(input [7:0] a, output [7:0] d);
    @(negedge mclk);
    sfrAddr = a;
    repeat (2) @(negedge mclk);
    d = sfrRdata;
  endtask
  task exec(input [7:0] op, input [7:0] a, input [7:0] b, output [7:0] ra, output [7:0] rb, output [1:0] fl);
    int n;
    @(negedge mclk);
    opStart = 1'b1;
    opCode = op;
    accIn = a;
    bIn = b;
    @(negedge mclk);
    opStart = 1'b0;
    accIn = ~a;
    bIn = ~b;
    n = 0;
    while (abWrite !== 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    ra = accOut;
    rb = bOut;
    fl = {ovOut, carryOut};
  endtask
endmodule

// ===== verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  wire opStart, sfrWr, abWrite, ovOut, carryOut, flagWrite, busy;
  wire [7:0] opCode, accIn, bIn, sfrAddr, sfrWdata, sfrRdata, accOut, bOut;
  logic [7:0] ra, rb, top, mid, lo, bx, d;
  logic [1:0] fl;
  int nMismatch = 0;
  int comparisons = 0;
  always #2.5 mclk = ~mclk;
  wide_mul_div_unit u_wide_mul_div_unit (.mclk(mclk), .sys_rst(sys_rst), .opStart(opStart), .opCode(opCode),
    .accIn(accIn), .bIn(bIn), .sfrWr(sfrWr), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
    .accOut(accOut), .bOut(bOut), .abWrite(abWrite), .ovOut(ovOut), .carryOut(carryOut),
    .flagWrite(flagWrite), .busy(busy));
  core_model u_core_model (.mclk(mclk), .sfrRdata(sfrRdata), .accOut(accOut), .bOut(bOut), .abWrite(abWrite),
    .ovOut(ovOut), .carryOut(carryOut), .opStart(opStart), .opCode(opCode), .accIn(accIn), .bIn(bIn),
    .sfrWr(sfrWr), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata));
  ////////////////////////////////////////////////////////////////
  task check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      nMismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("comparisons=%0d mismatches=%0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task run(input [7:0] mode, input [7:0] op, input [31:0] x, input [15:0] y);
    u_core_model.wr(8'hf7, mode);
    u_core_model.wr(8'hcf, x[31:24]);
    u_core_model.wr(8'hce, x[23:16]);
    u_core_model.wr(8'he6, x[15:8]);
    u_core_model.wr(8'he7, y[15:8]);
    u_core_model.exec(op, x[7:0], y[7:0], ra, rb, fl);
    check(abWrite, 1'b1);
    u_core_model.rd(8'hcf, top);
    u_core_model.rd(8'hce, mid);
    u_core_model.rd(8'he6, lo);
    u_core_model.rd(8'he7, bx);
  endtask
  task t_regs;
    logic [7:0] adr [5] = '{8'hce, 8'hcf, 8'he6, 8'he7, 8'hf7};
    foreach (adr[i]) begin
      u_core_model.rd(adr[i], d);
      check(d, 8'h00);
    end
    u_core_model.wr(8'hf7, 8'hff);
    u_core_model.rd(8'hf7, d);
    check(d, 8'hfd);
  endtask
  task t_byte;
    run(8'h00, 8'ha4, 32'hc8, 16'h1e);
    check({rb, ra, fl}, {16'h1770, 2'b10});
    run(8'h08, 8'h84, 32'hc8, 16'h1e);
    check({ra, rb, fl}, {16'h0614, 2'b00});
    run(8'h00, 8'h84, 32'hc8, 16'h00);
    check(fl, 2'b10);
  endtask
  task t_refuse;
    u_core_model.wr(8'hf7, 8'h00);
    u_core_model.wr(8'he6, 8'h33);
    u_core_model.exec(8'h00, 8'h02, 8'h03, ra, rb, fl);
    check({abWrite, busy}, 2'b00);
    fork
      u_core_model.exec(8'ha4, 8'h02, 8'h03, ra, rb, fl);
      begin
        repeat (3) @(negedge mclk);
        u_core_model.wr(8'he6, 8'h5a);
      end
    join
    check({ra, rb}, 16'h0600);
    u_core_model.rd(8'he6, d);
    check(d, 8'h33);
  endtask
  task t_wmul(input [7:0] m, input [15:0] x, input [15:0] y);
    logic [31:0] p;
    p = x * y;
    run(m, 8'ha4, {16'h0, x}, y);
    check({bx, rb, ra, lo}, p);
    check(fl, {p[31:16] != 16'h0, 1'b0});
  endtask
  task t_wdiv(input [15:0] x, input [15:0] y);
    run(8'h01, 8'h84, {16'h0, x}, y);
    check({ra, lo, rb, bx, fl}, {x / y, x % y, 2'b00});
    run(8'h01, 8'h84, {16'h0, x}, 16'h0);
    check(fl, 2'b10);
  endtask
  task t_ldiv(input [31:0] x, input [15:0] y);
    run(8'h09, 8'h84, x, y);
    check({ra, lo, mid, top, rb, bx, fl}, {x / y, 16'(x % y), 2'b00});
    run(8'h09, 8'h84, x, 16'h0);
    check(fl, 2'b10);
  endtask
  initial begin
    #50000;
    nMismatch++;
    conclude;
  end
  initial begin
    repeat (6) @(negedge mclk);
    sys_rst = 1'b0;
    t_regs;
    t_byte;
    t_refuse;
    t_wmul(8'h01, 16'h1234, 16'habcd);
    t_wmul(8'h09, 16'h0012, 16'h0034);
    t_wdiv(16'hfedc, 16'h0123);
    t_ldiv(32'h89abcdef, 16'h1234);
    conclude;
  end
endmodule

// ===== verif/wide_mul_div_chk.sv
`timescale 1ns/1ps
module wide_mul_div_chk (
  input wire       mclk,
  input wire       sys_rst,
  input wire       opStart,
  input wire [7:0] opCode,
  input wire       sfrWr,
  input wire [7:0] sfrAddr,
  input wire [7:0] sfrWdata,
  input wire [7:0] sfrRdata,
  input wire [7:0] accOut,
  input wire       abWrite,
  input wire       flagWrite,
  input wire       carryOut,
  input wire       busy
);
  logic [1:0] modeSel_ff;
  logic [5:0] busyCnt_ff;
  logic [5:0] wantCnt_ff;
  wire        take = opStart && !busy && (opCode == 8'ha4 || opCode == 8'h84);
  // shadow of the mode bits so the expected run length is known at issue
  always @(posedge mclk) begin
    if (sys_rst) begin
      modeSel_ff <= 2'h0;
      busyCnt_ff <= 6'h00;
      wantCnt_ff <= 6'h00;
    end else begin
      if (sfrWr && !busy && sfrAddr == 8'hf7) modeSel_ff <= {sfrWdata[3], sfrWdata[0]};
      busyCnt_ff <= busy ? busyCnt_ff + 6'h01 : 6'h00;
      if (take) wantCnt_ff <= !modeSel_ff[0] ? 6'h08 : (opCode == 8'ha4 || !modeSel_ff[1]) ? 6'h10 : 6'h20;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // busy covers the running cycles plus the one write-back cycle
  AST_LATENCY: assert property (abWrite |-> busyCnt_ff == wantCnt_ff + 6'h01)
    else $error("result after wrong cycle count");
  AST_BUSY_RISE: assert property (take |=> busy)
    else $error("busy not raised on issue");
  AST_BUSY_FALL: assert property ($fell(busy) |-> abWrite)
    else $error("busy dropped without result write");
  AST_FLAGS: assert property (abWrite |-> flagWrite && !carryOut)
    else $error("flags not written with carry clear");
  AST_PULSE: assert property (abWrite |=> !abWrite)
    else $error("result strobe longer than one cycle");
  AST_AFTER_BUSY: assert property (abWrite |-> $past(busy))
    else $error("result without a running operation");
  AST_HOLD: assert property (!abWrite |-> $stable(accOut))
    else $error("accumulator result changed without strobe");
  AST_MODE_RD: assert property (sfrWr && !busy && sfrAddr == 8'hf7 ##1 !sfrWr && sfrAddr == 8'hf7
    |=> sfrRdata == ($past(sfrWdata, 2) & 8'hfd))
    else $error("mode register readback wrong");
endmodule
bind wide_mul_div_unit wide_mul_div_chk u_wide_mul_div_chk (
  .mclk     (mclk),
  .sys_rst  (sys_rst),
  .opStart  (opStart),
  .opCode   (opCode),
  .sfrWr    (sfrWr),
  .sfrAddr  (sfrAddr),
  .sfrWdata (sfrWdata),
  .sfrRdata (sfrRdata),
  .accOut   (accOut),
  .abWrite  (abWrite),
  .flagWrite(flagWrite),
  .carryOut (carryOut),
  .busy     (busy)
);
